//--- spr_pkg.sv
// Constants, types and register map of the synthesizer post divider and page register block
// Summary of operation
// - Filter register bit 0 picks synth 0 loop filter: 0 external, 1 internal.
// - Filter register bit 1 picks synth 1 loop filter, same encoding.
// - Synth 0 phase value advances all its clocks by value/256 of a period.
// - Synth 1 phase value advances all its clocks by value/256 of a period.
// - Page bit 0 low maps serial addresses to 0x00-0x7E; 0x7F always reaches page.
// - Page bit 0 high maps serial addresses to the upper page from 0x80.
// - Divider A divides synth 0 by bits 22:0; software keeps bit 23 zero.
// - Divider B divides synth 0 by bits 22:0; software writes bit 23 zero.
// - Divider C bits 23:20 all ones gives frame pulse, period in bits 15:0.
// - Otherwise divider C gives a 50% clock divided by all 24 bits.
// - Odd divider C ratios near maximum rate may leave the 45-55% duty band.
// - Odd divider C ratios of 11 or more keep duty within 45-55%.
// - Even nonzero divider C ratios always keep duty within 45-55%; ratio 0 holds the output high.
// - Frame pulse related clock: 00 A, 01 B, 11 D, 10 reserved; width one period.
package spr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0]  ADDR_FILTER   = 8'h77;
	localparam logic [7:0]  ADDR_PHASE0   = 8'h78;
	localparam logic [7:0]  ADDR_PHASE1   = 8'h7A;
	localparam logic [7:0]  ADDR_PAGE     = 8'h7F;
	localparam logic [7:0]  ADDR_DIV_A    = 8'h80;
	localparam logic [7:0]  ADDR_DIV_B    = 8'h83;
	localparam logic [7:0]  ADDR_DIV_C    = 8'h86;
	localparam logic [6:0]  SER_PAGE_ADDR = 7'h7F;

	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [23:0] RST_DIV_A     = 24'h000002;
	localparam logic [23:0] RST_DIV_B     = 24'h000002;
	localparam logic [23:0] RST_DIV_C     = 24'h000040;

	localparam int          FILT_S0_BIT   = 0;
	localparam int          FILT_S1_BIT   = 1;
	localparam int          PAGE_BIT      = 0;
	localparam int          PH_W          = 8;
	localparam int          DIV_W         = 24;
	localparam int          DIV_AB_W      = 23;
	localparam int          FP_MODE_LSB   = 20;
	localparam logic [3:0]  FP_MODE_CODE  = 4'hF;
	localparam int          FP_SEL_LSB    = 16;
	localparam int          FP_POL_BIT    = 18;
	localparam int          FP_PER_W      = 16;
	localparam logic [1:0]  REL_A         = 2'h0;
	localparam logic [1:0]  REL_B         = 2'h1;
	localparam logic [1:0]  REL_D         = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		CM_CLOCK = 2'h1,
		CM_PULSE = 2'h2
	} spr_cmode_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [6:0] addr;
		logic [7:0] wdata;
	} spr_acc_t;

	typedef struct packed {
		logic s0_tick;
		logic s1_tick;
		logic s0_out_a;
		logic s0_out_b;
		logic s0_out_c;
	} spr_clk_t;

	typedef struct packed {
		logic [7:0]          filt;
		logic [PH_W-1:0]     ph0;
		logic [PH_W-1:0]     ph1;
		logic [7:0]          page;
		logic [DIV_W-1:0]    div_a;
		logic [DIV_W-1:0]    div_b;
		logic [DIV_W-1:0]    div_c;
		logic [PH_W-1:0]     ph_cnt0;
		logic [PH_W-1:0]     ph_cnt1;
		logic [DIV_W-1:0]    cnt_a;
		logic [DIV_W-1:0]    cnt_b;
		logic [DIV_W-1:0]    cnt_c;
		logic [FP_PER_W-1:0] fp_cnt;
		logic                fp_active;
		logic                rel_prev;
		spr_cmode_t          cmode;
		spr_clk_t            clk;
		logic [7:0]          rdata;
		logic                rvalid;
	} spr_state_t;

endpackage

//--- spr_core.sv
// Synthesizer configuration registers, phase advance and post dividers A, B, C of synthesizer 0
`timescale 1ns/1ps
module spr_core #(
	parameter int PHASE_W = 8                     // Phase step width, one period is 2**PHASE_W ref_clk cycles
) (
	input  wire logic             ref_clk,        // Block clock, 40 MHz
	input  wire logic             nrst,           // Asynchronous reset, active low
	input  wire spr_pkg::spr_acc_t acc,           // Byte access from the serial port front end
	input  wire logic             s0_div_d_rise,  // Rising edge of synth 0 divider D output, one cycle
	output logic [7:0]            acc_rdata,      // Read data, valid with acc_rvalid
	output logic                  acc_rvalid,     // Read answer pulse
	output logic                  s0_loop_filter_choice, // Synth 0 loop filter: 1 internal
	output logic                  s1_loop_filter_choice, // Synth 1 loop filter: 1 internal
	output spr_pkg::spr_clk_t     clk_out,        // Synth ticks and divided outputs
	output logic [23:0]           divide_ratio_c, // Active divider C setting
	output logic                  s0_pulse_mode   // Divider C in frame pulse mode
);
	import spr_pkg::*;

	// Elaboration check: the phase counter is sized by the package width
	if (PHASE_W != PH_W) begin : g_bad_phase_w
		$error("spr_core: PHASE_W must equal the phase register width");
	end

	spr_state_t st_r;
	spr_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Divider step: next count and 50% output; odd ratios hold high one tick longer
	function automatic logic [DIV_W:0] div_step(input logic [DIV_W-1:0] cnt,
		input logic [DIV_W-1:0] ratio);
		logic [DIV_W-1:0] n;
		logic [DIV_W-1:0] half;
		logic [DIV_W-1:0] nc;
		n = (ratio == '0) ? DIV_W'(1) : ratio;
		half = DIV_W'((n + DIV_W'(1)) >> 1);
		nc = (cnt >= n - DIV_W'(1)) ? '0 : cnt + DIV_W'(1);
		return {(nc < half), nc};
	endfunction

	// Seven-bit serial address to eight-bit register address
	function automatic logic [7:0] full_addr(input logic [6:0] a, input logic pg);
		return (a == SER_PAGE_ADDR) ? ADDR_PAGE : {pg, a};
	endfunction

	// Byte of a three-byte register, most significant byte at the lowest address
	function automatic logic [7:0] pick_byte(input logic [DIV_W-1:0] v, input logic [7:0] idx);
		case (idx)
			8'h00:   return v[23:16];
			8'h01:   return v[15:8];
			8'h02:   return v[7:0];
			default: return RST_BYTE;
		endcase
	endfunction

	function automatic logic [DIV_W-1:0] put_byte(input logic [DIV_W-1:0] v, input logic [7:0] idx,
		input logic [7:0] b);
		logic [DIV_W-1:0] r;
		r = v;
		case (idx)
			8'h00:   r[23:16] = b;
			8'h01:   r[15:8] = b;
			8'h02:   r[7:0] = b;
			default: r = v;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]       fa;
	logic [DIV_W:0]   step_a;
	logic [DIV_W:0]   step_b;
	logic [DIV_W:0]   step_c;
	logic             rel_clk;
	logic             rel_rise;
	logic [FP_PER_W-1:0] fp_per;

	always_comb begin
		st_nxt = st_r;
		fa = full_addr(acc.addr, st_r.page[PAGE_BIT]);
		st_nxt.rvalid = 1'b0;

		// Register writes take effect at the next edge, so the following access sees a new page
		if (acc.valid && acc.write) begin
			if (fa == ADDR_FILTER)
				st_nxt.filt = {6'h00, acc.wdata[1:0]};
			else if (fa == ADDR_PHASE0)
				st_nxt.ph0 = acc.wdata;
			else if (fa == ADDR_PHASE1)
				st_nxt.ph1 = acc.wdata;
			else if (fa == ADDR_PAGE)
				st_nxt.page = {7'h00, acc.wdata[PAGE_BIT]};
			else if (fa >= ADDR_DIV_A && fa < ADDR_DIV_B)
				st_nxt.div_a = put_byte(st_r.div_a, fa - ADDR_DIV_A, acc.wdata);
			else if (fa >= ADDR_DIV_B && fa < ADDR_DIV_C)
				st_nxt.div_b = put_byte(st_r.div_b, fa - ADDR_DIV_B, acc.wdata);
			else if (fa >= ADDR_DIV_C && fa < ADDR_DIV_C + 8'h03)
				st_nxt.div_c = put_byte(st_r.div_c, fa - ADDR_DIV_C, acc.wdata);
		end

		// Reads answer one cycle later; unmapped bytes read zero
		if (acc.valid && !acc.write) begin
			st_nxt.rvalid = 1'b1;
			if (fa == ADDR_FILTER)
				st_nxt.rdata = st_r.filt;
			else if (fa == ADDR_PHASE0)
				st_nxt.rdata = st_r.ph0;
			else if (fa == ADDR_PHASE1)
				st_nxt.rdata = st_r.ph1;
			else if (fa == ADDR_PAGE)
				st_nxt.rdata = st_r.page;
			else if (fa >= ADDR_DIV_A && fa < ADDR_DIV_B)
				st_nxt.rdata = pick_byte(st_r.div_a, fa - ADDR_DIV_A);
			else if (fa >= ADDR_DIV_B && fa < ADDR_DIV_C)
				st_nxt.rdata = pick_byte(st_r.div_b, fa - ADDR_DIV_B);
			else if (fa >= ADDR_DIV_C && fa < ADDR_DIV_C + 8'h03)
				st_nxt.rdata = pick_byte(st_r.div_c, fa - ADDR_DIV_C);
			else
				st_nxt.rdata = RST_BYTE;
		end

		// Synth period model: 2**PH_W steps; a tick falls earlier by the phase value
		st_nxt.ph_cnt0 = st_r.ph_cnt0 + PH_W'(1);
		st_nxt.ph_cnt1 = st_r.ph_cnt1 + PH_W'(1);
		st_nxt.clk.s0_tick = (PH_W'(st_r.ph_cnt0 + st_r.ph0) == '0);
		st_nxt.clk.s1_tick = (PH_W'(st_r.ph_cnt1 + st_r.ph1) == '0);

		// Mode of divider C
		st_nxt.cmode = (st_r.div_c[DIV_W-1:FP_MODE_LSB] == FP_MODE_CODE) ? CM_PULSE : CM_CLOCK;

		// Dividers A and B count synth 0 ticks, so they inherit its phase advance
		step_a = div_step(st_r.cnt_a, {1'b0, st_r.div_a[DIV_AB_W-1:0]});
		step_b = div_step(st_r.cnt_b, {1'b0, st_r.div_b[DIV_AB_W-1:0]});
		step_c = div_step(st_r.cnt_c, st_r.div_c);
		if (st_r.clk.s0_tick) begin
			st_nxt.cnt_a = step_a[DIV_W-1:0];
			st_nxt.clk.s0_out_a = step_a[DIV_W];
			st_nxt.cnt_b = step_b[DIV_W-1:0];
			st_nxt.clk.s0_out_b = step_b[DIV_W];
		end

		// Related clock for the frame pulse
		case (st_r.div_c[FP_SEL_LSB+1:FP_SEL_LSB])
			REL_A:   rel_clk = st_r.clk.s0_out_a;
			REL_B:   rel_clk = st_r.clk.s0_out_b;
			default: rel_clk = 1'b0;
		endcase
		rel_rise = (st_r.div_c[FP_SEL_LSB+1:FP_SEL_LSB] == REL_D) ? s0_div_d_rise
			: (rel_clk && !st_r.rel_prev);
		st_nxt.rel_prev = rel_clk;
		fp_per = (st_r.div_c[FP_PER_W-1:0] == '0) ? FP_PER_W'(1) : st_r.div_c[FP_PER_W-1:0];

		case (st_r.cmode)
			CM_CLOCK: begin
				st_nxt.fp_cnt = '0;
				st_nxt.fp_active = 1'b0;
				if (st_r.clk.s0_tick) begin
					st_nxt.cnt_c = step_c[DIV_W-1:0];
					st_nxt.clk.s0_out_c = step_c[DIV_W];
				end
			end
			CM_PULSE: begin
				st_nxt.cnt_c = '0;
				// Pulse spans one related period, once every fp_per related periods
				if (rel_rise) begin
					if (st_r.fp_cnt >= fp_per - FP_PER_W'(1)) begin
						st_nxt.fp_cnt = '0;
						st_nxt.fp_active = 1'b1;
					end else begin
						st_nxt.fp_cnt = st_r.fp_cnt + FP_PER_W'(1);
						st_nxt.fp_active = 1'b0;
					end
				end
				if (st_r.div_c[FP_SEL_LSB+1:FP_SEL_LSB] == 2'h2)
					st_nxt.fp_active = 1'b0;
				st_nxt.clk.s0_out_c = st_nxt.fp_active ^ st_r.div_c[FP_POL_BIT];
			end
			default: begin
				st_nxt.cmode = CM_CLOCK;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r.filt <= RST_BYTE;
			st_r.ph0 <= RST_BYTE;
			st_r.ph1 <= RST_BYTE;
			st_r.page <= RST_BYTE;
			st_r.div_a <= RST_DIV_A;
			st_r.div_b <= RST_DIV_B;
			st_r.div_c <= RST_DIV_C;
			st_r.ph_cnt0 <= '0;
			st_r.ph_cnt1 <= '0;
			st_r.cnt_a <= '0;
			st_r.cnt_b <= '0;
			st_r.cnt_c <= '0;
			st_r.fp_cnt <= '0;
			st_r.fp_active <= 1'b0;
			st_r.rel_prev <= 1'b0;
			st_r.cmode <= CM_CLOCK;
			st_r.clk <= '0;
			st_r.rdata <= RST_BYTE;
			st_r.rvalid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign acc_rdata = st_r.rdata;
	assign acc_rvalid = st_r.rvalid;
	assign s0_loop_filter_choice = st_r.filt[FILT_S0_BIT];
	assign s1_loop_filter_choice = st_r.filt[FILT_S1_BIT];
	assign clk_out = st_r.clk;
	assign divide_ratio_c = st_r.div_c;
	assign s0_pulse_mode = (st_r.cmode == CM_PULSE);

endmodule

//--- spr_core_checker.sv
// Assertion checker for the synthesizer register and divider block
`timescale 1ns/1ps
module spr_core_checker import spr_pkg::*; #(
	parameter int PHASE_W = 8                      // Phase width
) (
	input wire logic               ref_clk,        // Clock
	input wire logic               nrst,           // Reset
	input wire spr_pkg::spr_acc_t  acc,            // Access
	input wire logic               s0_div_d_rise,  // D edge
	input wire logic [7:0]         acc_rdata,      // Read data
	input wire logic               acc_rvalid,     // Read answer
	input wire logic               s0_loop_filter_choice, // Filter 0
	input wire logic               s1_loop_filter_choice, // Filter 1
	input wire spr_pkg::spr_clk_t  clk_out,        // Outputs
	input wire logic [23:0]        divide_ratio_c, // Ratio C
	input wire logic               s0_pulse_mode   // Pulse mode
);
	import spr_pkg::*;
	logic pg_r;
	logic wr;
	logic rd;
	assign wr = acc.valid && acc.write;
	assign rd = acc.valid && !acc.write;
	// Tracks the page bit as the host sees it
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst) pg_r <= 1'b0;
		else if (wr && acc.addr == SER_PAGE_ADDR) pg_r <= acc.wdata[PAGE_BIT];
	// Cycles since the last synth 0 phase write; a phase write may legally pull a tick close
	logic [3:0] ph0_age;
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst) ph0_age <= 4'hF;
		else if (wr && !pg_r && acc.addr == 7'h78) ph0_age <= 4'h0;
		else if (ph0_age != 4'hF) ph0_age <= ph0_age + 4'h1;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	a_read_answer: assert property (rd |=> acc_rvalid) else $error("read not answered");
	a_answer_cause: assert property (acc_rvalid |-> $past(rd)) else $error("stray answer");
	a_filter_zero: assert property (
		wr && !pg_r && acc.addr == 7'h77 |=> s0_loop_filter_choice == $past(acc.wdata[0]))
		else $error("filter 0 wrong");
	a_filter_one: assert property (
		wr && !pg_r && acc.addr == 7'h77 |=> s1_loop_filter_choice == $past(acc.wdata[1]))
		else $error("filter 1 wrong");
	a_ratio_c_top: assert property (
		wr && pg_r && acc.addr == 7'h06 |=> divide_ratio_c[23:16] == $past(acc.wdata))
		else $error("ratio c top byte wrong");
	a_page_read: assert property (
		rd && acc.addr == SER_PAGE_ADDR |=> acc_rdata == {7'h00, pg_r})
		else $error("page read wrong");
	a_pulse_on: assert property (
		divide_ratio_c[23:20] == FP_MODE_CODE |-> ##[0:1] s0_pulse_mode)
		else $error("pulse mode missing");
	a_clock_mode: assert property (
		divide_ratio_c[23:20] != FP_MODE_CODE |-> ##[0:1] !s0_pulse_mode)
		else $error("pulse mode wrong");
	a_tick_single: assert property (
		clk_out.s0_tick |=> (!clk_out.s0_tick || ph0_age < 4'h9) [*8])
		else $error("tick too close");
	a_reset_values: assert property (
		$rose(nrst) |-> divide_ratio_c == RST_DIV_C && !s0_loop_filter_choice)
		else $error("reset value wrong");
endmodule
bind spr_core spr_core_checker #(.PHASE_W(PHASE_W)) spr_core_checker_i (
	.ref_clk(ref_clk), .nrst(nrst), .acc(acc), .s0_div_d_rise(s0_div_d_rise),
	.acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
	.s0_loop_filter_choice(s0_loop_filter_choice), .s1_loop_filter_choice(s1_loop_filter_choice),
	.clk_out(clk_out), .divide_ratio_c(divide_ratio_c), .s0_pulse_mode(s0_pulse_mode));

//--- spr_host.sv
// Host model issuing byte accesses through the serial port front end
`timescale 1ns/1ps
module spr_host import spr_pkg::*; (
	input  wire logic             ref_clk,    // Clock
	output spr_pkg::spr_acc_t     acc,        // Access
	input  wire logic             acc_rvalid, // Read answer
	input  wire logic [7:0]       acc_rdata   // Read data
);
	import spr_pkg::*;
	logic pg;
	initial acc = '0;
	initial pg = 1'b0;
	// One access; a released bus shows inverted values
	task automatic go(logic w, logic [6:0] a, logic [7:0] d);
		@(posedge ref_clk);
		acc <= '{1'b1, w, a, d};
		@(posedge ref_clk);
		acc <= '{1'b0, w, ~a, ~d};
	endtask
	task automatic wr(logic [6:0] a, logic [7:0] d);
		if (pg && (a == 7'h00 || a == 7'h03)) d[7] = 1'b0;
		// A write to the page address updates the tracked page bit
		if (a == SER_PAGE_ADDR) pg = d[PAGE_BIT];
		go(1'b1, a, d);
	endtask
	task automatic rd(logic [6:0] a, output logic [7:0] d, output logic ok);
		go(1'b0, a, 8'h00);
		@(posedge ref_clk);
		ok = acc_rvalid;
		d = acc_rdata;
	endtask
endmodule

//--- tb_spr_core.sv
// Self-checking bench for the synthesizer register and divider block
`timescale 1ns/1ps
module tb_spr_core;
	import spr_pkg::*;
	localparam int T = 256;
	logic ref_clk, nrst, s0_div_d_rise, acc_rvalid, f0, f1, s0_pulse_mode;
	spr_acc_t acc;
	spr_clk_t clk_out;
	logic [7:0] acc_rdata, p, v;
	logic [23:0] divide_ratio_c;
	logic [71:0] dflt = {RST_DIV_A, RST_DIV_B, RST_DIV_C};
	int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'h552a, n, h, t;
	real t0;
	spr_core #(.PHASE_W(8)) spr_core_i (.ref_clk(ref_clk), .nrst(nrst), .acc(acc),
		.s0_div_d_rise(s0_div_d_rise), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
		.s0_loop_filter_choice(f0), .s1_loop_filter_choice(f1), .clk_out(clk_out),
		.divide_ratio_c(divide_ratio_c), .s0_pulse_mode(s0_pulse_mode));
	spr_host spr_host_i (.ref_clk(ref_clk), .acc(acc), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata));
	////////////////////////////////////////////////////////////////////////////////
	function int hi(int k);
		return (k + 1) / 2 * T;
	endfunction
	task stop_test;
		$display("Mismatches %0d of %0d compares", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(string nm, logic [23:0] e, logic [23:0] s);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rdc(logic [6:0] a, logic [7:0] e);
		logic [7:0] d;
		logic ok;
		spr_host_i.rd(a, d, ok);
		chk("read", {16'h0, e}, {16'h0, ok ? d : 8'hXX});
	endtask
	task w24(int s, logic [23:0] x);
		for (int j = 0; j < 3; j++) spr_host_i.wr(7'(3 * s + j), x[23 - 8 * j -: 8]);
	endtask
	// High and total cycles of one output period
	task meas(int s, output int hh, output int tt);
		logic b;
		hh = 0;
		b = 1'b1;
		// Skip a period, since a ratio change may cut the first one short
		repeat (2) begin
			while (b) begin @(posedge ref_clk); b = clk_out[2 - s]; end
			while (!b) begin @(posedge ref_clk); b = clk_out[2 - s]; end
		end
		while (b) begin hh++; @(posedge ref_clk); b = clk_out[2 - s]; end
		tt = hh;
		while (!b) begin tt++; @(posedge ref_clk); b = clk_out[2 - s]; end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		s0_div_d_rise <= (cyc % 20 == 19);
		if (cyc == 50000) begin
			n_mismatch++;
			stop_test;
		end
	end
	initial begin
		nrst = 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		foreach (dflt[i]) if (i < 4) rdc(i[0] ? 7'h78 : (i[1] ? 7'h7A : 7'h7F), 8'h00);
		rdc(7'h77, 8'h00);
		v = 8'($random(seed));
		spr_host_i.wr(7'h77, v);
		#1;
		chk("filter 0", {23'h0, v[0]}, {23'h0, f0});
		chk("filter 1", {23'h0, v[1]}, {23'h0, f1});
		rdc(7'h77, {6'h00, v[1:0]});
		spr_host_i.wr(7'h00, 8'h5A);
		rdc(7'h00, 8'h00);
		for (int k = 0; k < 2; k++) begin
			p = 8'h01 + 8'($unsigned($random(seed)) % 200);
			@(posedge clk_out[4 - k]);
			t0 = $realtime;
			spr_host_i.wr(k ? 7'h7A : 7'h78, p);
			@(posedge clk_out[4 - k]);
			chk("tick gap", 24'(T - p), 24'(int'(($realtime - t0) / 25.0)));
		end
		spr_host_i.wr(7'h7F, 8'h01);
		rdc(7'h7F, 8'h01);
		for (int i = 0; i < 9; i++) rdc(7'(i), dflt[71 - 8 * i -: 8]);
		for (int s = 0; s < 3; s++) begin
			n = 2 + $unsigned($random(seed)) % 8;
			w24(s, 24'(n));
			meas(s, h, t);
			chk("high", 24'(hi(n)), 24'(h));
			chk("period", 24'(n * T), 24'(t));
		end
		chk("ratio c", 24'(n), divide_ratio_c);
		w24(0, 24'h000002);
		w24(2, 24'hF00002);
		@(posedge ref_clk);
		#1;
		chk("pulse mode", 24'h1, {23'h0, s0_pulse_mode});
		meas(2, h, t);
		chk("pulse width", 24'(2 * T), 24'(h));
		chk("pulse period", 24'(4 * T), 24'(t));
		w24(2, 24'hF30003);
		meas(2, h, t);
		chk("d pulse width", 24'd20, 24'(h));
		chk("d pulse period", 24'd60, 24'(t));
		spr_host_i.wr(7'h06, 8'hF7);
		meas(2, h, t);
		chk("inverted pulse high", 24'd40, 24'(h));
		chk("inverted pulse period", 24'd60, 24'(t));
		spr_host_i.wr(7'h06, 8'hF2);
		repeat (2) @(posedge ref_clk);
		h = 0;
		repeat (100) begin
			@(posedge ref_clk);
			h += clk_out.s0_out_c;
		end
		chk("reserved select", 24'h0, 24'(h));
		spr_host_i.wr(7'h7F, 8'h00);
		rdc(7'h06, 8'h00);
		stop_test;
	end
endmodule
